// *** hdl/energy_saving_voltage_ref.sv ***
`timescale 1ns/1ps
`default_nettype none
module energy_saving_voltage_ref import esv_pkg::*; #(
	parameter int TUNE_TICK_CYCLES = TUNE_TICK_CYC,
	parameter int FILT_TICK_CYCLES = FILT_TICK_CYC
) (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	// Avalon-MM slave
	input wire logic [7:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// Drive state from the power stage
	input wire logic RUN_I,
	input wire logic [15:0] OUT_FREQ_I,
	input wire logic [15:0] LOAD_POWER_I,
	// Voltage command and monitors
	output logic [15:0] VOLT_REF_O,
	output logic SAVING_ACTIVE_O,
	output logic [15:0] POWER_MON_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
			input logic [7:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [15:0] pct_to_tenth(input logic [7:0] p);
		return 16'(p) * 16'h000a;
	endfunction

	// ==========================================
	// Register file
	logic ack, next_ack;
	logic [31:0] rdata, next_rdata;
	logic [31:0] mode, next_mode;
	logic [15:0] freq_set, next_freq_set;
	logic [31:0] limits, next_limits;
	logic [31:0] tune, next_tune;
	logic [15:0] coef, next_coef;
	logic [31:0] motor, next_motor;
	logic [7:0] mconst, next_mconst;
	logic [31:0] wr;
	logic [16:0] lut;
	logic req;
	esv_state_t state, next_state;
	logic [15:0] vref, next_vref;
	logic [15:0] pmon, next_pmon;

	assign req = AVS_READ_I | AVS_WRITE_I;
	// One wait cycle: read data are latched while waitrequest is high
	assign AVS_WAITREQUEST_O = req & ~ack;
	assign AVS_READDATA_O = rdata;

	// Decode, byte-lane merge and range limiting of software settings
	always_comb begin
		next_ack = req & ~ack;
		next_rdata = rdata;
		next_mode = mode;
		next_freq_set = freq_set;
		next_limits = limits;
		next_tune = tune;
		next_coef = coef;
		next_motor = motor;
		next_mconst = mconst;
		wr = 32'h0;
		lut = 17'h0;
		if (AVS_READ_I && !ack) begin
			case (AVS_ADDRESS_I)
				REG_MODE: next_rdata = mode;
				REG_SET_FREQ: next_rdata = {16'h0, freq_set};
				REG_LIMITS: next_rdata = limits;
				REG_TUNE: next_rdata = tune;
				REG_COEF: next_rdata = {16'h0, coef};
				REG_MOTOR: next_rdata = motor;
				REG_INIT: next_rdata = {24'h0, mconst};
				REG_STATUS: next_rdata = {13'h0, (state == ST_SAVE), 2'(state), vref};
				REG_POWER: next_rdata = {16'h0, pmon};
				default: next_rdata = 32'h0;
			endcase
		end
		if (AVS_WRITE_I && ack) begin
			case (AVS_ADDRESS_I)
				REG_MODE: next_mode = merge(mode, AVS_WRITEDATA_I, AVS_BYTEENABLE_I) & MODE_MASK;
				REG_SET_FREQ: next_freq_set = 16'(merge({16'h0, freq_set}, AVS_WRITEDATA_I,
						AVS_BYTEENABLE_I));
				REG_LIMITS: next_limits = merge(limits, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				REG_TUNE: begin
					wr = merge(tune, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
					wr[TLIM_POS +: 8] = clamp8(wr[TLIM_POS +: 8], 8'h00, TLIM_MAX);
					wr[TPER_POS +: 8] = clamp8(wr[TPER_POS +: 8], TPER_MIN, TPER_MAX);
					wr[STEP_FULL_POS +: 8] = clamp8(wr[STEP_FULL_POS +: 8], STEP_MIN, STEP_MAX);
					wr[STEP_LOW_POS +: 8] = clamp8(wr[STEP_LOW_POS +: 8], STEP_MIN, STEP_MAX);
					next_tune = wr;
				end
				REG_COEF: next_coef = 16'(merge({16'h0, coef}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
				REG_MOTOR: begin
					wr = merge(motor, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
					wr[RATIO_POS +: 8] = clamp8(wr[RATIO_POS +: 8], RATIO_MIN, RATIO_MAX);
					wr[FILT_TC_POS +: 8] = clamp8(wr[FILT_TC_POS +: 8], TC_MIN, TC_MAX);
					lut = motor_coef(wr[CODE_POS +: 8]);
					if (AVS_BYTEENABLE_I[1] && lut[16]) begin
						next_coef = lut[15:0];
					end
					next_motor = wr;
				end
				REG_INIT: begin
					wr = merge({24'h0, mconst}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
					next_mconst = wr[7:0];
					lut = motor_coef(wr[7:0]);
					if (AVS_BYTEENABLE_I[1] && wr[INIT_GO_BIT]) begin
						next_motor[CODE_POS +: 8] = wr[7:0];
						if (lut[16]) begin
							next_coef = lut[15:0];
						end
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ack <= 1'b0;
			rdata <= 32'h0;
			mode <= MODE_RST;
			freq_set <= FREQ_RST;
			limits <= LIMITS_RST;
			tune <= TUNE_RST;
			coef <= COEF_RST;
			motor <= MOTOR_RST;
			mconst <= MCONST_RST;
		end else begin
			ack <= next_ack;
			rdata <= next_rdata;
			mode <= next_mode;
			freq_set <= next_freq_set;
			limits <= next_limits;
			tune <= next_tune;
			coef <= next_coef;
			motor <= next_motor;
			mconst <= next_mconst;
		end
	end

	// ==========================================
	// Frequency-dependent limits and ratio, voltage-dependent step
	logic [15:0] up_lim, lo_lim, ratio_now, step_now, vf, v_opt, v_red, v_out;
	logic [7:0] tune_lim, tune_per;
	logic [15:0] lim10;

	assign tune_lim = tune[TLIM_POS +: 8];
	assign tune_per = tune[TPER_POS +: 8];
	assign lim10 = pct_to_tenth(tune_lim);

	lin_interp #(.W(16), .X0(FREQ_6HZ), .X1(FREQ_60HZ)) u_up_lim (
		.x_i(OUT_FREQ_I),
		.y0_i(pct_to_tenth(limits[UP_LO_POS +: 8])),
		.y1_i(pct_to_tenth(limits[UP_HI_POS +: 8])),
		.y_o(up_lim)
	);
	lin_interp #(.W(16), .X0(FREQ_6HZ), .X1(FREQ_60HZ)) u_lo_lim (
		.x_i(OUT_FREQ_I),
		.y0_i(pct_to_tenth(limits[LO_LO_POS +: 8])),
		.y1_i(pct_to_tenth(limits[LO_HI_POS +: 8])),
		.y_o(lo_lim)
	);
	lin_interp #(.W(16), .X0(FREQ_6HZ), .X1(FREQ_15HZ)) u_ratio (
		.x_i(OUT_FREQ_I),
		.y0_i(16'(motor[RATIO_POS +: 8])),
		.y1_i(PCT_FULL),
		.y_o(ratio_now)
	);
	lin_interp #(.W(16), .X0(VOLT_5PCT), .X1(VOLT_RATED)) u_step (
		.x_i(v_red),
		.y0_i(16'(tune[STEP_LOW_POS +: 8])),
		.y1_i(16'(tune[STEP_FULL_POS +: 8])),
		.y_o(step_now)
	);

	// ==========================================
	// Voltage path, sequencing and tuning
	logic [31:0] filt_cnt, next_filt_cnt, tick_cnt, next_tick_cnt;
	logic [7:0] per_cnt, next_per_cnt;
	logic [23:0] pacc, next_pacc;
	logic signed [16:0] trim, next_trim;
	logic dir, next_dir;
	logic [15:0] last_p, next_last_p;
	logic filt_tick, tune_tick, tune_fire, es_ok;
	logic [15:0] pfilt;
	logic [31:0] vf_w, red_w;
	logic [47:0] opt_w;
	logic signed [25:0] pdiff;
	logic signed [17:0] tuned, tstep;
	logic [15:0] v_tuned;

	assign pfilt = pacc[23:8];
	assign filt_tick = (filt_cnt == 32'(FILT_TICK_CYCLES - 1));
	assign tune_tick = (tick_cnt == 32'(TUNE_TICK_CYCLES - 1));
	assign tune_fire = tune_tick && (per_cnt >= 8'(tune_per - 8'h01));
	assign es_ok = mode[MODE_SAVE_BIT] && (freq_set <= FREQ_100HZ);

	always_comb begin
		next_filt_cnt = filt_tick ? 32'h0 : 32'(filt_cnt + 32'h1);
		next_tick_cnt = tune_tick ? 32'h0 : 32'(tick_cnt + 32'h1);
		// Filter on a fractional accumulator so small errors still settle
		pdiff = $signed({2'b00, LOAD_POWER_I, 8'h00}) - $signed({2'b00, pacc});
		next_pacc = pacc;
		if (filt_tick) begin
			next_pacc = 24'($signed({2'b00, pacc}) + pdiff / $signed({18'h0,
					motor[FILT_TC_POS +: 8]}));
		end
		// V/f base voltage, held at rated above 60 Hz
		vf_w = 32'(OUT_FREQ_I) * 32'(VOLT_RATED) / 32'(FREQ_60HZ);
		vf = (vf_w > 32'(VOLT_RATED)) ? VOLT_RATED : vf_w[15:0];
		opt_w = (48'(coef) * 48'(pfilt) * 48'(vf)) >> OPT_SHIFT;
		v_opt = (opt_w > 48'h0_ffff) ? 16'hffff : opt_w[15:0];
		red_w = 32'(v_opt) * 32'(ratio_now) / 32'(PCT_FULL);
		v_red = red_w[15:0];
		tuned = $signed({2'b00, v_red}) + $signed({trim[16], trim});
		if (tuned[17]) begin
			v_tuned = 16'h0;
		end else if (tuned[16]) begin
			v_tuned = 16'hffff;
		end else begin
			v_tuned = tuned[15:0];
		end
		// Upper limit is tested first, so it wins if limits cross and the value is above it
		if (v_tuned > up_lim) begin
			v_out = up_lim;
		end else if (v_tuned < lo_lim) begin
			v_out = lo_lim;
		end else begin
			v_out = v_tuned;
		end
		// Sequencing
		next_state = state;
		case (state)
			ST_STOP: if (RUN_I) next_state = ST_ACCEL;
			ST_ACCEL: begin
				if (!RUN_I) next_state = ST_STOP;
				else if (!es_ok) next_state = ST_VF;
				else if (OUT_FREQ_I == freq_set) next_state = ST_SAVE;
			end
			ST_SAVE: begin
				if (!RUN_I) next_state = ST_STOP;
				else if (!es_ok) next_state = ST_VF;
				else if (OUT_FREQ_I != freq_set) next_state = ST_ACCEL;
			end
			ST_VF: begin
				if (!RUN_I) next_state = ST_STOP;
				else if (es_ok) next_state = ST_ACCEL;
			end
			default: next_state = ST_STOP;
		endcase
		// Tuning: reverse when the last step raised power
		next_per_cnt = per_cnt;
		next_trim = trim;
		next_dir = dir;
		next_last_p = last_p;
		tstep = $signed({2'b00, step_now});
		if (state != ST_SAVE || tune_lim == 8'h00) begin
			next_per_cnt = 8'h00;
			next_trim = 17'sh0;
			next_dir = 1'b0;
			next_last_p = pfilt;
		end else if (tune_tick) begin
			next_per_cnt = tune_fire ? 8'h00 : 8'(per_cnt + 8'h01);
			if (tune_fire) begin
				next_dir = (pfilt > last_p) ? ~dir : dir;
				tuned = next_dir ? ($signed({trim[16], trim}) + tstep) :
						($signed({trim[16], trim}) - tstep);
				if (tuned > $signed({2'b00, lim10})) begin
					tuned = $signed({2'b00, lim10});
				end else if (tuned < -$signed({2'b00, lim10})) begin
					tuned = -$signed({2'b00, lim10});
				end
				next_trim = tuned[16:0];
				next_last_p = pfilt;
			end
		end
		case (state)
			ST_SAVE: next_vref = v_out;
			ST_ACCEL, ST_VF: next_vref = vf;
			default: next_vref = 16'h0;
		endcase
		next_pmon = LOAD_POWER_I;
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state <= ST_STOP;
			filt_cnt <= 32'h0;
			tick_cnt <= 32'h0;
			per_cnt <= 8'h00;
			pacc <= 24'h0;
			trim <= 17'sh0;
			dir <= 1'b0;
			last_p <= 16'h0;
			vref <= 16'h0;
			pmon <= 16'h0;
		end else begin
			state <= next_state;
			filt_cnt <= next_filt_cnt;
			tick_cnt <= next_tick_cnt;
			per_cnt <= next_per_cnt;
			pacc <= next_pacc;
			trim <= next_trim;
			dir <= next_dir;
			last_p <= next_last_p;
			vref <= next_vref;
			pmon <= next_pmon;
		end
	end

	assign VOLT_REF_O = vref;
	assign SAVING_ACTIVE_O = (state == ST_SAVE);
	assign POWER_MON_O = pmon;

	// ==========================================
	// Checks
	clamp_high_a: assert property (state == ST_SAVE |=> VOLT_REF_O <= $past(up_lim))
		else $error("saving voltage above upper limit");
	clamp_low_a: assert property ((state == ST_SAVE && up_lim >= lo_lim)
		|=> VOLT_REF_O >= $past(lo_lim)) else $error("saving voltage below lower limit");
	lim_ends_a: assert property (OUT_FREQ_I >= FREQ_60HZ |->
		up_lim == pct_to_tenth(limits[UP_HI_POS +: 8]) &&
		lo_lim == pct_to_tenth(limits[LO_HI_POS +: 8])) else $error("limit at 60 Hz wrong");
	tune_off_a: assert property (tune_lim == 8'h00 |=> trim == 17'sh0)
		else $error("trim nonzero with tuning off");
	tune_hold_a: assert property ((state == ST_SAVE && tune_lim != 8'h00 && !tune_fire)
		|=> $stable(trim)) else $error("trim moved between tuning cycles");
	step_full_a: assert property (v_red >= VOLT_RATED
		|-> step_now == 16'(tune[STEP_FULL_POS +: 8])) else $error("full step wrong");
	ratio_top_a: assert property (OUT_FREQ_I >= FREQ_15HZ |-> ratio_now == PCT_FULL)
		else $error("ratio not full above 15 Hz");
	coef_load_a: assert property ((AVS_WRITE_I && ack && AVS_ADDRESS_I == REG_MOTOR
		&& AVS_BYTEENABLE_I == 4'hf && AVS_WRITEDATA_I[15:8] == 8'h29)
		|=> coef == 16'h2d36) else $error("motor code did not load coefficient");
	init_copy_a: assert property ((AVS_WRITE_I && ack && AVS_ADDRESS_I == REG_INIT
		&& AVS_BYTEENABLE_I == 4'hf && AVS_WRITEDATA_I[INIT_GO_BIT])
		|=> motor[CODE_POS +: 8] == $past(AVS_WRITEDATA_I[7:0])) else $error("init copy lost");
	vf_only_a: assert property (!mode[MODE_SAVE_BIT] |=> state != ST_SAVE)
		else $error("saving while mode digit off");
	save_entry_a: assert property ($rose(SAVING_ACTIVE_O)
		|-> $past(OUT_FREQ_I) == $past(freq_set)) else $error("saving before set frequency");
	release_a: assert property (freq_set > FREQ_100HZ |=> !SAVING_ACTIVE_O)
		else $error("saving above 100 Hz");
	monitor_a: assert property (##1 POWER_MON_O == $past(LOAD_POWER_I))
		else $error("power monitor stale");
	range_a: assert property (tune_per >= TPER_MIN && tune_per <= TPER_MAX &&
		motor[RATIO_POS +: 8] >= RATIO_MIN && motor[RATIO_POS +: 8] <= RATIO_MAX)
		else $error("setting out of range");
	trim_bound_a: assert property ($signed({1'b0, trim[16] ? -trim : trim})
		<= $signed({2'b00, lim10})) else $error("trim outside tuning range");
	filt_pass_a: assert property ((filt_tick && motor[FILT_TC_POS +: 8] == 8'h01)
		|=> pacc == $past({LOAD_POWER_I, 8'h00})) else $error("filter wrong");
	bus_ans_a: assert property ((req && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
		else $error("waitrequest held too long");
endmodule
`default_nettype wire

// *** hdl/esv_pkg.sv ***
`default_nettype none
package esv_pkg;
	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int TUNE_TICK_NS = 100_000_000;
	localparam int FILT_TICK_NS = 7_000_000;
	localparam int TUNE_TICK_CYC = TUNE_TICK_NS / CLK_PERIOD_NS;
	localparam int FILT_TICK_CYC = FILT_TICK_NS / CLK_PERIOD_NS;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_SET_FREQ = 8'h04;
	localparam logic [7:0] REG_LIMITS = 8'h08;
	localparam logic [7:0] REG_TUNE = 8'h0c;
	localparam logic [7:0] REG_COEF = 8'h10;
	localparam logic [7:0] REG_MOTOR = 8'h14;
	localparam logic [7:0] REG_INIT = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	localparam logic [7:0] REG_POWER = 8'h20;
	// ==========================================
	// Field positions
	localparam int MODE_SAVE_BIT = 2;
	localparam int UP_HI_POS = 0;
	localparam int UP_LO_POS = 8;
	localparam int LO_HI_POS = 16;
	localparam int LO_LO_POS = 24;
	localparam int TLIM_POS = 0;
	localparam int TPER_POS = 8;
	localparam int STEP_FULL_POS = 16;
	localparam int STEP_LOW_POS = 24;
	localparam int RATIO_POS = 0;
	localparam int CODE_POS = 8;
	localparam int FILT_TC_POS = 16;
	localparam int INIT_GO_BIT = 8;
	// ==========================================
	// Reset values
	localparam logic [31:0] MODE_RST = 32'h0000_0004;
	localparam logic [31:0] MODE_MASK = 32'h0000_000f;
	localparam logic [15:0] FREQ_RST = 16'h0000;
	localparam logic [31:0] LIMITS_RST = 32'h0c32_1078;
	localparam logic [31:0] TUNE_RST = 32'h0205_0a00;
	localparam logic [15:0] COEF_RST = 16'h2d36;
	localparam logic [31:0] MOTOR_RST = 32'h0014_2964;
	localparam logic [7:0] MCONST_RST = 8'h29;
	// ==========================================
	// Scales: frequency 0.01 Hz, voltage 0.1 %
	localparam logic [15:0] FREQ_6HZ = 16'h0258;
	localparam logic [15:0] FREQ_15HZ = 16'h05dc;
	localparam logic [15:0] FREQ_60HZ = 16'h1770;
	localparam logic [15:0] FREQ_100HZ = 16'h2710;
	localparam logic [15:0] VOLT_RATED = 16'h03e8;
	localparam logic [15:0] VOLT_5PCT = 16'h0032;
	localparam logic [15:0] PCT_FULL = 16'h0064;
	localparam logic [7:0] TLIM_MAX = 8'h14;
	localparam logic [7:0] TPER_MIN = 8'h01;
	localparam logic [7:0] TPER_MAX = 8'h64;
	localparam logic [7:0] STEP_MIN = 8'h01;
	localparam logic [7:0] STEP_MAX = 8'h64;
	localparam logic [7:0] RATIO_MIN = 8'h32;
	localparam logic [7:0] RATIO_MAX = 8'h64;
	localparam logic [7:0] TC_MIN = 8'h01;
	localparam logic [7:0] TC_MAX = 8'hff;
	localparam int OPT_SHIFT = 23;

	typedef enum logic [1:0] {ST_STOP, ST_ACCEL, ST_SAVE, ST_VF} esv_state_t;

	// Initial coefficient per motor code, bit 16 marks a known code
	function automatic logic [16:0] motor_coef(input logic [7:0] code);
		logic [15:0] c;
		c = 16'h0000;
		case (code)
			8'h00: c = 16'h7094;
			8'h01: c = 16'h5762;
			8'h02: c = 16'h422c;
			8'h03: c = 16'h3d40;
			8'h04: c = 16'h3002;
			8'h05: c = 16'h2503;
			8'h06: c = 16'h1c65;
			8'h07: c = 16'h1b84;
			8'h08: c = 16'h18a9;
			8'h09: c = 16'h169b;
			8'h0a: c = 16'h143b;
			8'h0b: c = 16'h1213;
			8'h0c: c = 16'h0ee8;
			8'h0d: c = 16'h0dfa;
			8'h0e: c = 16'h0c3f;
			8'h0f: c = 16'h0906;
			8'h20: c = 16'he128;
			8'h21: c = 16'haec4;
			8'h22: c = 16'h97e0;
			8'h23: c = 16'h7a80;
			8'h24: c = 16'h5ff0;
			8'h25: c = 16'h4a06;
			8'h26: c = 16'h38ca;
			8'h27: c = 16'h3708;
			8'h28: c = 16'h3152;
			8'h29: c = 16'h2d36;
			8'h2a: c = 16'h2876;
			8'h2b: c = 16'h2426;
			8'h2c: c = 16'h1dd0;
			8'h2d: c = 16'h1bf4;
			8'h2e: c = 16'h1a40;
			8'h2f: c = 16'h120c;
			8'h30: c = 16'h101a;
			8'h31: c = 16'h0e27;
			8'h32: c = 16'h0d3c;
			8'h33: c = 16'h0bc5;
			8'h34: c = 16'h0b68;
			8'h35: c = 16'h0a99;
			8'h36: c = 16'h0880;
			default: c = 16'h0000;
		endcase
		return {(c != 16'h0000), c};
	endfunction
endpackage
`default_nettype wire

// *** hdl/lin_interp.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Straight-line interpolation between two fixed abscissas, clamped at both ends
module lin_interp #(
	parameter int W = 16,
	parameter logic [W-1:0] X0 = '0,
	parameter logic [W-1:0] X1 = '1
) (
	// Operands
	input wire logic [W-1:0] x_i,
	input wire logic [W-1:0] y0_i,
	input wire logic [W-1:0] y1_i,
	// Result
	output logic [W-1:0] y_o
);
	localparam logic signed [2*W+3:0] SPAN = (2*W+4)'(X1 - X0);
	logic [W-1:0] xc;
	logic signed [2*W+3:0] prod;
	logic signed [2*W+3:0] sum;

	// Divide by a constant span, so synthesis folds it into a multiply
	always_comb begin
		if (x_i <= X0) begin
			xc = X0;
		end else if (x_i >= X1) begin
			xc = X1;
		end else begin
			xc = x_i;
		end
		prod = ($signed({2'b00, y1_i}) - $signed({2'b00, y0_i})) * $signed({2'b00, W'(xc - X0)});
		sum = $signed({{(W+4){1'b0}}, y0_i}) + prod / SPAN;
		y_o = sum[W-1:0];
	end
endmodule
`default_nettype wire

// *** verification/energy_saving_voltage_ref_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module energy_saving_voltage_ref_tb import esv_pkg::*;;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, r;
	logic waitreq, saving, run = 1'b0;
	logic [15:0] set_freq = 16'h0, load = 16'h0;
	logic [15:0] freq, power, vref, mon, v1;
	logic [15:0] q[$];
	logic [7:0] codes [5] = '{8'h00, 8'h0f, 8'h20, 8'h36, 8'h10};
	logic [15:0] coefs [5] = '{16'h7094, 16'h0906, 16'he128, 16'h0880, 16'h0880};
	int bad_count = 0;
	int n_checks = 0;
	int i;
	// ==========================================
	// Clock, design and far side
	initial begin
		forever #12.5 clk = ~clk;
	end
	energy_saving_voltage_ref #(.TUNE_TICK_CYCLES(20), .FILT_TICK_CYCLES(4))
	energy_saving_voltage_ref_inst (.CLK_SYS_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
		.AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
		.RUN_I(run), .OUT_FREQ_I(freq), .LOAD_POWER_I(power), .VOLT_REF_O(vref),
		.SAVING_ACTIVE_O(saving), .POWER_MON_O(mon));
	power_stage_model power_stage_model_inst (.clk_i(clk), .rstn_i(rstn), .run_i(run),
		.set_freq_i(set_freq), .load_i(load), .out_freq_o(freq), .load_power_o(power));
	// ==========================================
	// Reference model: limits interpolated 6..60 Hz, V/f line capped at rated
	function automatic int lim(input int f, input int a6, input int a60);
		if (f <= 600) return a6 * 10;
		if (f >= 6000) return a60 * 10;
		return a6 * 10 + (a60 - a6) * 10 * (f - 600) / 5400;
	endfunction
	function automatic int vfv(input int f);
		return (f / 6 > 1000) ? 1000 : f / 6;
	endfunction
	// ==========================================
	// Compare, report and bus tasks
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic limit_hit(input int n, input int lim_n);
		if (n >= lim_n) begin
			bad_count++;
			end_of_test();
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		limit_hit(n, 50);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk32(r, e);
	endtask
	task automatic go(input logic [15:0] f);
		bus(1'b1, REG_SET_FREQ, {16'h0, f});
		set_freq <= f;
		run <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic wait_vref(input logic [15:0] e);
		int n;
		n = 0;
		while (vref !== e && n < 20000) begin
			@(posedge clk);
			n++;
		end
		limit_hit(n, 20000);
		chk16(vref, e);
	endtask
	// Saving must not start before the output frequency equals the setting
	task automatic wait_save();
		int n;
		n = 0;
		while (saving !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		limit_hit(n, 5000);
		chk16(freq, set_freq);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hb1031782));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rchk(REG_MODE, 32'h0000_0004);
		rchk(REG_LIMITS, 32'h0c32_1078);
		rchk(REG_TUNE, 32'h0205_0a00);
		rchk(REG_MOTOR, 32'h0014_2964);
		rchk(REG_COEF, 32'h0000_2d36);
		rchk(8'h40, 32'h0000_0000);
		// Out-of-range fields are clamped on write
		bus(1'b1, REG_TUNE, 32'h0000_ff00);
		rchk(REG_TUNE, 32'h0101_6400);
		bus(1'b1, REG_TUNE, TUNE_RST);
		bus(1'b1, REG_MOTOR, 32'h0014_2914);
		rchk(REG_MOTOR, 32'h0014_2932);
		for (i = 0; i < 5; i++) begin
			bus(1'b1, REG_MOTOR, {16'h0014, codes[i], 8'h64});
			rchk(REG_COEF, {16'h0, coefs[i]});
		end
		bus(1'b1, REG_INIT, 32'h0000_0105);
		rchk(REG_MOTOR, 32'h0014_0564);
		rchk(REG_COEF, 32'h0000_2503);
		bus(1'b1, REG_INIT, 32'h0000_0129);
		// Monitor follows load power one clock later
		@(posedge clk);
		q.push_back(power);
		for (i = 0; i < 12; i++) begin
			@(posedge clk);
			load <= 16'($urandom_range(1000));
			chk16(mon, q.pop_front());
			q.push_back(power);
		end
		load <= 16'h0;
		// Plain V/f when the mode bit is clear
		bus(1'b1, REG_MODE, 32'h0);
		go(16'd3000);
		wait_vref(16'(vfv(3000)));
		chk16({15'h0, saving}, 16'h0);
		rchk(REG_STATUS, {13'h0, 3'b011, 16'(vfv(3000))});
		run <= 1'b0;
		wait_vref(16'h0);
		// Saving with no load sits on the lower limit
		bus(1'b1, REG_MODE, 32'h4);
		go(16'd600);
		wait_save();
		wait_vref(16'(lim(600, 12, 50)));
		go(16'd3300);
		wait_save();
		wait_vref(16'(lim(3300, 12, 50)));
		load <= 16'd1000;
		wait_vref(16'(lim(3300, 16, 120)));
		// Mid load lands between limits; a larger coefficient raises it
		load <= 16'd400;
		go(16'd6000);
		wait_save();
		repeat (3000) @(posedge clk);
		v1 = vref;
		chk16({15'h0, (v1 > 16'd500 && v1 < 16'd1200)}, 16'h1);
		// Tuning with a 2 % range, downward first, never past the tuning range
		bus(1'b1, REG_TUNE, 32'h0205_0a02);
		repeat (1000) @(posedge clk);
		chk16({15'h0, (vref < v1 && vref + 16'd20 >= v1)}, 16'h1);
		bus(1'b1, REG_MOTOR, 32'h0014_2064);
		wait_vref(16'(lim(6000, 16, 120)));
		// Setting above 100 Hz falls back to V/f
		go(16'd12000);
		wait_vref(16'(vfv(12000)));
		chk16({15'h0, saving}, 16'h0);
		end_of_test();
	end
endmodule
`default_nettype wire

// *** verification/power_stage_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Power stage: ramps output frequency toward the setting, reports load power
module power_stage_model #(
	parameter int RAMP = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Commands from the bench
	input wire logic run_i,
	input wire logic [15:0] set_freq_i,
	input wire logic [15:0] load_i,
	// Feedback to the block
	output logic [15:0] out_freq_o,
	output logic [15:0] load_power_o
);
	logic [15:0] tgt;
	assign tgt = run_i ? set_freq_i : 16'h0000;
	// Rate limited ramp, so the block always sees a real acceleration phase
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			out_freq_o <= 16'h0000;
			load_power_o <= 16'h0000;
		end else begin
			load_power_o <= load_i;
			if (int'(out_freq_o) + RAMP < int'(tgt)) begin
				out_freq_o <= out_freq_o + 16'(RAMP);
			end else if (int'(out_freq_o) > int'(tgt) + RAMP) begin
				out_freq_o <= out_freq_o - 16'(RAMP);
			end else begin
				out_freq_o <= tgt;
			end
		end
	end
endmodule
`default_nettype wire
